// ==== bench/tb_top.sv ====
// Self-checking bench for the flash self-programming control block.
// Assumes fspc_pkg and fspc_consts.svh are compiled first; APB master only.
`timescale 1ns/1ps
`include "fspc_consts.svh"

module tb_top
   import fspc_pkg::*;
;
   // ************************************************************
   // Signals and design instance
   // ************************************************************
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata_q, rd;
   logic        pready_q, pslverr_q, cpu_stall_q, irq_q, er;
   logic        flash_wr_en_q, flash_erase_q, flash_mem_type_q;
   logic [15:0] flash_wr_addr_q;
   logic [23:0] flash_wr_data_q;
   logic [9:0]  flash_erase_row_q;
   logic [2:0]  flash_erase_rows_q;
   logic [15:0] wr_a [32];
   logic [23:0] wr_d [32];
   logic [9:0]  er_row;
   logic [2:0]  er_rows;
   int          err_total, checked, wr_n, er_n, cyc, i, op;
   localparam int unsigned OPC = 8;

   // Short operation time keeps the run brief
   fspc_top #(.OP_CYCLES(OPC)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
      .pslverr_q(pslverr_q), .cpu_stall_q(cpu_stall_q), .irq_q(irq_q),
      .flash_wr_en_q(flash_wr_en_q), .flash_wr_addr_q(flash_wr_addr_q),
      .flash_wr_data_q(flash_wr_data_q), .flash_erase_q(flash_erase_q),
      .flash_erase_row_q(flash_erase_row_q), .flash_erase_rows_q(flash_erase_rows_q),
      .flash_mem_type_q(flash_mem_type_q));

   // Clock and flash-side monitor
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (flash_wr_en_q === 1'b1) begin
         if (wr_n < 32) begin
            wr_a[wr_n] = flash_wr_addr_q;
            wr_d[wr_n] = flash_wr_data_q;
         end
         wr_n++;
      end
      if (flash_erase_q === 1'b1) begin
         er_n++;
         er_row = flash_erase_row_q;
         er_rows = flash_erase_rows_q;
      end
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   function automatic logic [23:0] ew(input int k);
      return 24'hC0_0000 + 24'(k) * 24'h00_0101;
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No local limit: only the watchdog ends a missing answer
      do begin
         @(posedge pclk);
      end while (pready_q !== 1'b1);
      rd = prdata_q;
      er = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdck(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(name, rd, exp);
   endtask

   // Two writes then a trigger that must not start anything
   task automatic bad(input logic [7:0] a1, input logic [31:0] d1, input logic [7:0] a2, input logic [31:0] d2);
      wr(a1, d1);
      wr(a2, d2);
      wr(`FSPC_OFS_CTRL, 32'h0000_8001);
      #1;
      check("stall no unlock", cpu_stall_q, 1'b0);
      rdck("ctrl no unlock", `FSPC_OFS_CTRL, 32'h0000_0001);
   endtask

   // Unlock, launch, and follow the operation to its end
   task automatic run_op(input logic [15:0] ctl, input int span);
      int t0;
      wr(`FSPC_OFS_KEY, {24'h00_0000, `FSPC_KEY_FIRST});
      wr(`FSPC_OFS_KEY, {24'h00_0000, `FSPC_KEY_SECOND});
      check("no early commit", wr_n, 0);
      er_n = 0;
      wr(`FSPC_OFS_CTRL, {16'h0000, ctl});
      #1;
      t0 = cyc;
      rdck("ctrl busy", `FSPC_OFS_CTRL, {16'h0000, ctl});
      #1;
      check("stall busy", cpu_stall_q, 1'b1);
      // Row write while busy must be ignored; later row and address checks catch it
      wr(`FSPC_OFS_ROW, 32'h0000_03FF);
      while (cpu_stall_q === 1'b1 && cyc - t0 < 1000) begin
         @(posedge pclk);
         #1;
      end
      check("stall span", 32'((cyc - t0 >= span) && (cyc - t0 <= span + 6)), 1);
      rdck("ctrl done", `FSPC_OFS_CTRL, {16'h0000, ctl & 16'h7FFF});
      rdck("status done", `FSPC_OFS_STATUS, 32'h0000_8000);
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      pclk = 0;
      presetn = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdck("ctrl reset", `FSPC_OFS_CTRL, 32'h0000_0000);
      rdck("status reset", `FSPC_OFS_STATUS, 32'h0000_0000);
      rdck("mask reset", `FSPC_OFS_MASK, 32'h0000_0000);
      rdck("key reads zero", `FSPC_OFS_KEY, 32'h0000_0000);
      check("mapped no error", er, 1'b0);
      apb(1'b0, 8'h40, 32'h0000_0000);
      check("unmapped error", er, 1'b1);
      bad(`FSPC_OFS_CTRL, 32'h0000_0000, `FSPC_OFS_MASK, 32'h0000_0000);
      wr(`FSPC_OFS_KEY, 32'h0000_0055);
      bad(`FSPC_OFS_MASK, 32'h0000_0000, `FSPC_OFS_KEY, 32'h0000_00AA);
      bad(`FSPC_OFS_KEY, 32'h0000_00AA, `FSPC_OFS_KEY, 32'h0000_0055);
      // Row program with one latch word overwritten; no commit may happen while loading
      wr_n = 0;
      wr(`FSPC_OFS_ROW, 32'h0000_02A5);
      wr(`FSPC_OFS_LIDX, 32'h0000_0000);
      for (i = 0; i < 32; i++) begin
         wr(`FSPC_OFS_LDATA, (i == 5) ? 32'h005A_5A5A : {8'h00, ew(i)});
      end
      wr(`FSPC_OFS_LIDX, 32'h0000_0005);
      wr(`FSPC_OFS_LDATA, {8'h00, ew(5)});
      run_op(16'h8000, 32 + OPC);
      check("row words", wr_n, 32);
      for (i = 0; i < 32; i++) begin
         check("word addr", wr_a[i], {10'h2A5, 5'(i), 1'b0});
         check("word data", wr_d[i], ew(i));
      end
      check("irq masked", irq_q, 1'b0);
      wr(`FSPC_OFS_MASK, 32'h0000_8000);
      @(posedge pclk);
      #1;
      check("irq raised", irq_q, 1'b1);
      wr(`FSPC_OFS_STATUS, 32'h0000_8000);
      rdck("status cleared", `FSPC_OFS_STATUS, 32'h0000_0000);
      check("irq cleared", irq_q, 1'b0);
      // Each erase size from an unaligned row
      for (op = 1; op < 4; op++) begin
         wr(`FSPC_OFS_ROW, 32'h0000_0007);
         wr_n = 0;
         run_op(16'h8000 | 16'(op) | 16'((op % 2) << 2), OPC);
         check("erase pulse", er_n, 1);
         check("erase rows", er_rows, 1 << (op - 1));
         check("erase row", er_row, 7 & ~((1 << (op - 1)) - 1));
         check("mem type", flash_mem_type_q, op % 2);
         check("irq on done", irq_q, 1'b1);
         wr(`FSPC_OFS_STATUS, 32'h0000_8000);
      end
      report_and_stop();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #200000;
      err_total++;
      report_and_stop();
   end
endmodule

// ==== design/fspc_top.sv ====
// Flash self-programming sequencer with APB registers, holding latches and interrupt.
// Assumes a single 100 MHz clock, asynchronous active-low reset and an APB master.
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "fspc_consts.svh"

module fspc_top
   import fspc_pkg::*;
#(
   parameter int unsigned OP_CYCLES = `FSPC_OP_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata_q,
   output logic             pready_q,
   output logic             pslverr_q,
   output logic             cpu_stall_q,
   output logic             irq_q,
   output logic             flash_wr_en_q,
   output logic      [15:0] flash_wr_addr_q,
   output logic      [23:0] flash_wr_data_q,
   output logic             flash_erase_q,
   output logic      [9:0]  flash_erase_row_q,
   output logic      [2:0]  flash_erase_rows_q,
   output logic             flash_mem_type_q
);

   // ************************************************************
   // Helpers
   // ************************************************************
   // Rows covered by an operation code
   function automatic logic [2:0] rows_of(input fspc_op_type op);
      case (op)
         FSPC_OP_ERASE2: rows_of = 3'h2;
         FSPC_OP_ERASE4: rows_of = 3'h4;
         default:        rows_of = 3'h1;
      endcase
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   fspc_state_type state_q, state_d;
   fspc_key_type   key_q, key_d;
   logic [15:0]    ctrl_q;
   logic [15:0]    flag_q, mask_q;
   logic [9:0]     row_q;
   logic [4:0]     lidx_q, widx_q;
   logic [31:0]    cnt_q;
   logic [23:0]    latch_q [0:`FSPC_ROW_WORDS-1];

   // ************************************************************
   // APB decode
   // ************************************************************
   wire         setup      = psel & ~penable;
   wire         wr_fire    = psel & penable & pready_q & pwrite;
   wire         a_ctrl     = (paddr == `FSPC_OFS_CTRL);
   wire         a_key      = (paddr == `FSPC_OFS_KEY);
   wire         a_status   = (paddr == `FSPC_OFS_STATUS);
   wire         a_mask     = (paddr == `FSPC_OFS_MASK);
   wire         a_row      = (paddr == `FSPC_OFS_ROW);
   wire         a_lidx     = (paddr == `FSPC_OFS_LIDX);
   wire         a_ldata    = (paddr == `FSPC_OFS_LDATA);
   wire         mapped     = a_ctrl | a_key | a_status | a_mask | a_row | a_lidx | a_ldata;
   wire         idle       = (state_q == FSPC_IDLE);
   wire         go         = wr_fire & a_ctrl & pwdata[`FSPC_CTRL_TRIG] & idle
                             & (key_q == FSPC_KEY_ARMED);
   wire         ctrl_wr    = wr_fire & a_ctrl & idle;
   wire         ldata_wr   = wr_fire & a_ldata & idle;
   wire         done       = (state_q == FSPC_DONE);
   wire fspc_op_type cur_op = fspc_op_type'(ctrl_q[1:0]);
   wire [2:0]   nrows      = rows_of(cur_op);
   wire [9:0]   row_base   = row_q & ~(10'(nrows) - 10'h001);
   wire [15:0]  flag_clr   = (wr_fire & a_status) ? pwdata[15:0] : 16'h0000;
   wire [15:0]  flag_set   = done ? (16'h0001 << `FSPC_FLAG_DONE) : 16'h0000;
   wire [31:0]  rd_mux     = a_ctrl   ? {16'h0000, ctrl_q} :
                             a_status ? {16'h0000, flag_q} :
                             a_mask   ? {16'h0000, mask_q} :
                             a_row    ? {22'h00_0000, row_q} :
                             a_lidx   ? {27'h000_0000, lidx_q} : 32'h0000_0000;

   // Unlock key: any write other than the next key step disarms
   always_comb begin
      key_d = key_q;
      if (wr_fire) begin
         if (a_key && pwdata[7:0] == `FSPC_KEY_FIRST)
            key_d = FSPC_KEY_HALF;
         else if (a_key && pwdata[7:0] == `FSPC_KEY_SECOND && key_q == FSPC_KEY_HALF)
            key_d = FSPC_KEY_ARMED;
         else
            key_d = FSPC_KEY_NONE;
      end
   end

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         FSPC_IDLE: if (go) begin
            state_d = (fspc_op_type'(pwdata[1:0]) == FSPC_OP_PROG_ROW) ? FSPC_PROG : FSPC_WAIT;
         end
         FSPC_PROG: if (widx_q == 5'(`FSPC_ROW_WORDS - 1)) begin
            state_d = FSPC_WAIT;
         end
         FSPC_WAIT: if (cnt_q == 32'h0000_0000) begin
            state_d = FSPC_DONE;
         end
         FSPC_DONE: state_d = FSPC_IDLE;
         default:   state_d = FSPC_IDLE;
      endcase
   end

   // ************************************************************
   // Registers
   // ************************************************************
   // APB answer: ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
         prdata_q  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Control, trigger and software settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `FSPC_CTRL_RST;
         mask_q <= 16'h0000;
         row_q  <= 10'h000;
         key_q  <= FSPC_KEY_NONE;
      end else begin
         key_q <= key_d;
         if (ctrl_wr)
            ctrl_q <= {go, pwdata[14:0]};
         else if (done)
            ctrl_q[`FSPC_CTRL_TRIG] <= 1'b0;
         if (wr_fire & a_mask)
            mask_q <= pwdata[15:0];
         if (wr_fire & a_row & idle)
            row_q <= pwdata[9:0];
      end
   end

   // Sticky flags, set beats clear, and interrupt level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 16'h0000;
         irq_q  <= 1'b0;
      end else begin
         flag_q <= (flag_q & ~flag_clr) | flag_set;
         irq_q  <= |(flag_q & mask_q);
      end
   end

   // Holding latches: last write to an index wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lidx_q <= 5'h00;
      end else if (wr_fire & a_lidx & idle) begin
         lidx_q <= pwdata[4:0];
      end else if (ldata_wr) begin
         lidx_q <= lidx_q + 5'h01;
      end
   end

   // Latch array storage, no reset needed
   always_ff @(posedge pclk) begin
      if (ldata_wr)
         latch_q[lidx_q] <= pwdata[23:0];
   end

   // Sequencer, duration counter and flash array strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q            <= FSPC_IDLE;
         cnt_q              <= 32'h0000_0000;
         widx_q             <= 5'h00;
         cpu_stall_q        <= 1'b0;
         flash_wr_en_q      <= 1'b0;
         flash_wr_addr_q    <= 16'h0000;
         flash_wr_data_q    <= 24'h00_0000;
         flash_erase_q      <= 1'b0;
         flash_erase_row_q  <= 10'h000;
         flash_erase_rows_q <= 3'h0;
         flash_mem_type_q   <= 1'b0;
      end else begin
         state_q       <= state_d;
         cpu_stall_q   <= (state_d != FSPC_IDLE);
         flash_wr_en_q <= (state_q == FSPC_PROG);
         flash_erase_q <= 1'b0;
         if (state_q == FSPC_IDLE) begin
            widx_q <= 5'h00;
            cnt_q  <= 32'(OP_CYCLES - 1);
         end
         if (state_q == FSPC_PROG) begin
            flash_wr_addr_q <= {row_q[9:0], 5'h00, 1'b0} | {10'h000, widx_q, 1'b0};
            flash_wr_data_q <= latch_q[widx_q];
            widx_q          <= widx_q + 5'h01;
         end
         if (state_q == FSPC_WAIT && cnt_q != 32'h0000_0000)
            cnt_q <= cnt_q - 32'h0000_0001;
         if (state_q == FSPC_WAIT && state_d == FSPC_DONE && cur_op != FSPC_OP_PROG_ROW) begin
            flash_erase_q      <= 1'b1;
            flash_erase_row_q  <= row_base;
            flash_erase_rows_q <= nrows;
         end
         if (go)
            flash_mem_type_q <= pwdata[`FSPC_CTRL_MEM];
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   stall_hold_a: assert property (go |=> cpu_stall_q [*2]) else $error("core not stalled");
   stall_release_a: assert property ($fell(cpu_stall_q) |-> $past(state_q) == FSPC_DONE)
      else $error("stall dropped early");
   trig_launch_a: assert property (go |=> ctrl_q[`FSPC_CTRL_TRIG] && state_q != FSPC_IDLE)
      else $error("trigger did not launch");
   trig_clear_a: assert property (done |=> !ctrl_q[`FSPC_CTRL_TRIG] && state_q == FSPC_IDLE)
      else $error("trigger not cleared");
   flag_set_a: assert property (done |=> flag_q[`FSPC_FLAG_DONE]) else $error("flag not set");
   flag_cause_a: assert property ($rose(flag_q[`FSPC_FLAG_DONE]) |-> $past(done))
      else $error("flag set without completion");
   op_select_a: assert property (go && pwdata[1:0] != 2'b00 |=> state_q == FSPC_WAIT)
      else $error("erase took wrong path");
   erase_align_a: assert property (flash_erase_q |-> (flash_erase_row_q & (10'(flash_erase_rows_q)
      - 10'h001)) == 10'h000) else $error("erase block misaligned");
   latch_commit_a: assert property (flash_wr_en_q |-> $past(state_q) == FSPC_PROG)
      else $error("latch commit outside programming");
   duration_a: assert property (done |-> $past(cnt_q) == 32'h0000_0000)
      else $error("operation ended before its duration");
   locked_a: assert property (key_q != FSPC_KEY_ARMED && ctrl_wr |=> !ctrl_q[`FSPC_CTRL_TRIG])
      else $error("started without unlock");

   prog_run_c: cover property (go ##1 state_q == FSPC_PROG ##[1:40] state_q == FSPC_WAIT);
   erase_run_c: cover property (flash_erase_q && flash_erase_rows_q == 3'h4);
   irq_c: cover property ($rose(irq_q));
   clear_race_c: cover property (done && wr_fire && a_status);

endmodule

// ==== include/fspc_consts.svh ====
// Offsets, field positions, reset values and timing for the flash self-programming control block.
// Assumes a 100 MHz APB clock and a 32-bit APB data path.
//
// Overview of operation
// - The core is held stalled for the whole program or erase operation.
// - Writing one to control bit 15 launches the selected operation only if idle and the two prior writes put 55 then AA in the key register.
// - Hardware clears control bit 15 when the operation completes.
// - Status bit 15 resets to zero and hardware sets it on completion.
// - The control register selects erase size, memory type and the start.
// - Erase 1, 2 or 4 rows of 32 words; program one row; rows aligned.
// - Latched data commits only when programming runs; later latch writes override.
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define FSPC_OFS_CTRL      8'h00
`define FSPC_OFS_KEY       8'h04
`define FSPC_OFS_STATUS    8'h08
`define FSPC_OFS_MASK      8'h0C
`define FSPC_OFS_ROW       8'h10
`define FSPC_OFS_LIDX      8'h14
`define FSPC_OFS_LDATA     8'h18

// ************************************************************
// Fields, keys, reset values
// ************************************************************
`define FSPC_CTRL_TRIG     15
`define FSPC_CTRL_MEM      2
`define FSPC_FLAG_DONE     15
`define FSPC_KEY_FIRST     8'h55
`define FSPC_KEY_SECOND    8'hAA
`define FSPC_CTRL_RST      16'h0000
`define FSPC_ROW_WORDS     32

// ************************************************************
// Timing
// ************************************************************
`define FSPC_CLK_NS        10
`define FSPC_OP_TIME_NS    20000
`define FSPC_OP_CYCLES     ((`FSPC_OP_TIME_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS)

`endif

// ==== include/fspc_pkg.sv ====
// Types shared by the flash self-programming control block.
// Assumes the constants header is compiled alongside.
package fspc_pkg;

   // Sequencer states, Gray coded along idle, program, wait, done
   typedef enum logic [1:0] {
      FSPC_IDLE = 2'b00,
      FSPC_PROG = 2'b01,
      FSPC_WAIT = 2'b11,
      FSPC_DONE = 2'b10
   } fspc_state_type;

   // Operation select in control bits 1:0
   typedef enum logic [1:0] {
      FSPC_OP_PROG_ROW = 2'b00,
      FSPC_OP_ERASE1   = 2'b01,
      FSPC_OP_ERASE2   = 2'b10,
      FSPC_OP_ERASE4   = 2'b11
   } fspc_op_type;

   // Unlock progress
   typedef enum logic [1:0] {
      FSPC_KEY_NONE  = 2'b00,
      FSPC_KEY_HALF  = 2'b01,
      FSPC_KEY_ARMED = 2'b11
   } fspc_key_type;

endpackage
